/* File: verilog/sideband_pkg.sv */
// Constants and carrier types for host-side sideband and interrupt routing
package sideband_pkg;

  // ==========================================
  // Legacy interrupt line indices
  localparam int IRQ_COUNT = 16;
  localparam int IRQ_GENERAL_IO_0 = 3;
  localparam int IRQ_GENERAL_IO_1 = 4;
  localparam int IRQ_GENERAL_IO_2 = 5;
  localparam int IRQ_GENERAL_IO_3 = 7;
  localparam int IRQ_SERIAL = 9;
  localparam int IRQ_LED_A = 10;
  localparam int IRQ_LED_B = 11;
  localparam int IRQ_LED = 12;
  localparam int IRQ_VIDEO_EN = 15;
  localparam logic [15:0] IRQ_PRESENT = 16'hDEB8;
  localparam int GPIO_COUNT = 4;
  localparam int VIDEO_WIDTH = 8;

  // ==========================================
  // Command codes on the bus command lines
  localparam logic [3:0] CMD_SPECIAL = 4'h1;
  localparam logic [3:0] CMD_CFG_READ = 4'hA;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hB;

  // ==========================================
  // Mux configuration
  typedef struct packed {
    logic led_enable;
    logic serial_irq_enable;
    logic ring_enable;
  } mux_cfg_t;

  localparam mux_cfg_t CFG_RESET = '{led_enable: 1'b0, serial_irq_enable: 1'b0,
                                     ring_enable: 1'b0};

  // Two-signal view of a two-way pin; oe_n low means driving
  typedef struct packed {
    logic out;
    logic oe_n;
  } pin_drive_t;

  typedef enum logic [1:0] {
    DRV_IDLE = 2'b00,
    DRV_LOW = 2'b01,
    DRV_HIGH = 2'b11
  } shz_state_t;

endpackage

/* File: verilog/host_sideband.sv */
// Host-side sideband signalling and interrupt pin routing
`timescale 1ns/1ps

module host_sideband (
  input wire logic ref_clk,
  input wire logic reset_n,
  // Configuration, from same-clock logic
  input wire sideband_pkg::mux_cfg_t cfg_in,
  input wire logic cfg_load,
  // Core requests, same clock
  input wire logic stop_req,
  input wire logic addr_decode_hit,
  input wire logic cycle_active,
  input wire logic [3:0] cycle_cmd,
  input wire logic write_data_phase,
  input wire logic data_parity_bad,
  input wire logic addr_parity_bad_primary,
  input wire logic addr_parity_bad_secondary,
  input wire logic master_need,
  input wire logic power_state_change,
  input wire logic socket_a_irq,
  input wire logic socket_b_irq,
  input wire logic [15:0] card_irq_route,
  input wire logic serial_irq_frame,
  input wire logic socket_a_led,
  input wire logic socket_b_led,
  input wire logic led_state,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_dir_out,
  input wire logic card_is_16bit,
  input wire logic ring_select_b,
  input wire logic [7:0] video_data,
  // Pins from outside
  input wire logic config_select_pin,
  input wire logic device_select_pin_n,
  input wire logic grant_pin_n,
  input wire logic [15:0] irq_pin_in,
  input wire logic [1:0] socket_ring_indicate_n,
  // Status to core
  output logic config_selected,
  output logic any_claimed,
  output logic grant_held,
  output logic [3:0] gpio_in,
  output logic video_port_enable_in,
  // Pin drives
  output logic stop_out_n,
  output logic stop_oe_n,
  output logic devsel_out_n,
  output logic devsel_oe_n,
  output logic perr_out_n,
  output logic perr_oe_n,
  output logic syserr_oe_n,
  output logic request_out_n,
  output logic request_oe_n,
  output logic pm_event_oe_n,
  output logic bus_int_a_oe_n,
  output logic bus_int_b_oe_n,
  output logic [15:0] irq_out,
  output logic [15:0] irq_oe_n,
  output logic ring_indicate_out_n,
  output logic ring_oe_n,
  output logic [7:0] video_out,
  output logic [7:0] video_oe_n
);

  // ==========================================
  // Input synchronisers (pins only)
  logic [1:0] cfgsel_sync;
  logic [1:0] devsel_sync;
  logic [1:0] grant_sync;
  logic [1:0] ring_a_sync;
  logic [1:0] ring_b_sync;
  logic [15:0] irq_sync1;
  logic [15:0] irq_sync2;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cfgsel_sync <= 2'h0;
      devsel_sync <= 2'h3;
      grant_sync <= 2'h3;
      ring_a_sync <= 2'h3;
      ring_b_sync <= 2'h3;
      irq_sync1 <= 16'h0000;
      irq_sync2 <= 16'h0000;
    end else begin
      cfgsel_sync <= {cfgsel_sync[0], config_select_pin};
      devsel_sync <= {devsel_sync[0], device_select_pin_n};
      grant_sync <= {grant_sync[0], grant_pin_n};
      ring_a_sync <= {ring_a_sync[0], socket_ring_indicate_n[0]};
      ring_b_sync <= {ring_b_sync[0], socket_ring_indicate_n[1]};
      irq_sync1 <= irq_pin_in;
      irq_sync2 <= irq_sync1;
    end
  end

  // ==========================================
  // Configuration bits
  sideband_pkg::mux_cfg_t cfg;

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      cfg <= sideband_pkg::CFG_RESET;
    end else if (cfg_load) begin
      cfg <= cfg_in;
    end
  end

  // ==========================================
  // Sampled status
  logic cfg_cmd;
  assign cfg_cmd = (cycle_cmd == sideband_pkg::CMD_CFG_READ) ||
                   (cycle_cmd == sideband_pkg::CMD_CFG_WRITE);

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      config_selected <= 1'b0;
      any_claimed <= 1'b0;
      grant_held <= 1'b0;
    end else begin
      config_selected <= cycle_active && cfg_cmd && cfgsel_sync[1];
      any_claimed <= !devsel_sync[1];
      grant_held <= !grant_sync[1];
    end
  end

  // ==========================================
  // Sustained three-state drivers: active low, then one clock high, then float
  function automatic sideband_pkg::shz_state_t shz_next(input logic want);
    shz_next = want ? sideband_pkg::DRV_LOW : sideband_pkg::DRV_IDLE;
  endfunction

  sideband_pkg::shz_state_t stop_st;
  sideband_pkg::shz_state_t devsel_st;
  sideband_pkg::shz_state_t perr_st;
  logic stop_want;
  logic devsel_want;
  logic perr_want;

  assign stop_want = cycle_active && stop_req;
  assign devsel_want = cycle_active && (addr_decode_hit || config_selected);
  assign perr_want = write_data_phase && data_parity_bad &&
                     (cycle_cmd != sideband_pkg::CMD_SPECIAL);

  // Low phase is followed by a forced high phase so the line never floats from low
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stop_st <= sideband_pkg::DRV_IDLE;
    end else if (stop_want) begin
      stop_st <= sideband_pkg::DRV_LOW;
    end else if (stop_st == sideband_pkg::DRV_LOW) begin
      stop_st <= sideband_pkg::DRV_HIGH;
    end else begin
      stop_st <= shz_next(1'b0);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      devsel_st <= sideband_pkg::DRV_IDLE;
    end else if (devsel_want) begin
      devsel_st <= sideband_pkg::DRV_LOW;
    end else if (devsel_st == sideband_pkg::DRV_LOW) begin
      devsel_st <= sideband_pkg::DRV_HIGH;
    end else begin
      devsel_st <= shz_next(1'b0);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      perr_st <= sideband_pkg::DRV_IDLE;
    end else if (perr_want) begin
      perr_st <= sideband_pkg::DRV_LOW;
    end else if (perr_st == sideband_pkg::DRV_LOW) begin
      perr_st <= sideband_pkg::DRV_HIGH;
    end else begin
      perr_st <= shz_next(1'b0);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      stop_out_n <= 1'b1;
      stop_oe_n <= 1'b1;
      devsel_out_n <= 1'b1;
      devsel_oe_n <= 1'b1;
      perr_out_n <= 1'b1;
      perr_oe_n <= 1'b1;
    end else begin
      stop_out_n <= !stop_want;
      stop_oe_n <= !(stop_want || stop_st == sideband_pkg::DRV_LOW);
      devsel_out_n <= !devsel_want;
      devsel_oe_n <= !(devsel_want || devsel_st == sideband_pkg::DRV_LOW);
      perr_out_n <= !perr_want;
      perr_oe_n <= !(perr_want || perr_st == sideband_pkg::DRV_LOW);
    end
  end

  // ==========================================
  // System error, request, power event, bus interrupts
  logic apar_prev_primary;
  logic apar_prev_secondary;
  logic serr_pending;
  logic serr_detect;

  assign serr_detect = (addr_parity_bad_primary && !apar_prev_primary) ||
                       (addr_parity_bad_secondary && !apar_prev_secondary);

  // A detection that lands during a pulse waits one clock, so no report is lost or widened
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      apar_prev_primary <= 1'b0;
      apar_prev_secondary <= 1'b0;
      serr_pending <= 1'b0;
    end else begin
      apar_prev_primary <= addr_parity_bad_primary;
      apar_prev_secondary <= addr_parity_bad_secondary;
      serr_pending <= (serr_detect || serr_pending) && !syserr_oe_n;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      syserr_oe_n <= 1'b1;
      request_out_n <= 1'b1;
      request_oe_n <= 1'b1;
      pm_event_oe_n <= 1'b1;
      bus_int_a_oe_n <= 1'b1;
      bus_int_b_oe_n <= 1'b1;
    end else begin
      // One clock per rising detection; a held error input gives no further pulses
      syserr_oe_n <= !((serr_detect || serr_pending) && syserr_oe_n);
      request_out_n <= !master_need;
      request_oe_n <= 1'b0;
      pm_event_oe_n <= !power_state_change;
      bus_int_a_oe_n <= !socket_a_irq;
      bus_int_b_oe_n <= !socket_b_irq;
    end
  end

  // ==========================================
  // Legacy interrupt pin multiplexing
  logic [15:0] next_irq_out;
  logic [15:0] next_irq_oe_n;
  logic [3:0] gpio_idx [4];

  assign gpio_idx[0] = 4'(sideband_pkg::IRQ_GENERAL_IO_0);
  assign gpio_idx[1] = 4'(sideband_pkg::IRQ_GENERAL_IO_1);
  assign gpio_idx[2] = 4'(sideband_pkg::IRQ_GENERAL_IO_2);
  assign gpio_idx[3] = 4'(sideband_pkg::IRQ_GENERAL_IO_3);

  always_comb begin
    next_irq_out = card_irq_route & sideband_pkg::IRQ_PRESENT;
    next_irq_oe_n = ~sideband_pkg::IRQ_PRESENT;
    if (cfg.led_enable) begin
      next_irq_out[sideband_pkg::IRQ_LED] = led_state;
    end
    if (cfg.serial_irq_enable) begin
      next_irq_out[sideband_pkg::IRQ_SERIAL] = !serial_irq_frame;
      next_irq_out[sideband_pkg::IRQ_VIDEO_EN] = 1'b0;
      next_irq_oe_n[sideband_pkg::IRQ_VIDEO_EN] = 1'b1;
      next_irq_out[sideband_pkg::IRQ_LED_A] = !socket_a_led;
      next_irq_out[sideband_pkg::IRQ_LED_B] = !socket_b_led;
      for (int i = 0; i < sideband_pkg::GPIO_COUNT; i++) begin
        next_irq_out[gpio_idx[i]] = gpio_out[i];
        next_irq_oe_n[gpio_idx[i]] = !gpio_dir_out[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      irq_out <= 16'h0000;
      irq_oe_n <= 16'hFFFF;
      gpio_in <= 4'h0;
      video_port_enable_in <= 1'b0;
    end else begin
      irq_out <= next_irq_out;
      irq_oe_n <= next_irq_oe_n;
      for (int i = 0; i < sideband_pkg::GPIO_COUNT; i++) begin
        gpio_in[i] <= cfg.serial_irq_enable && irq_sync2[gpio_idx[i]];
      end
      video_port_enable_in <= cfg.serial_irq_enable &&
                              irq_sync2[sideband_pkg::IRQ_VIDEO_EN];
    end
  end

  // ==========================================
  // Video port and ring indicate
  logic ring_sel;
  assign ring_sel = ring_select_b ? ring_b_sync[1] : ring_a_sync[1];

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      video_out <= 8'h00;
      video_oe_n <= 8'hFF;
      ring_indicate_out_n <= 1'b1;
      ring_oe_n <= 1'b1;
    end else begin
      video_out <= video_data;
      video_oe_n <= {8{!video_port_enable_in}};
      ring_indicate_out_n <= ring_sel;
      ring_oe_n <= !(card_is_16bit && cfg.ring_enable);
    end
  end

endmodule

/* File: testbench/host_bus_model.sv */
// Host bus partner: arbiter and wired pin levels
`timescale 1ns/1ps
module host_bus_model (
  input wire logic ref_clk,
  input wire logic request_out_n,
  input wire logic request_oe_n,
  input wire logic devsel_out_n,
  input wire logic devsel_oe_n,
  input wire logic [15:0] irq_out,
  input wire logic [15:0] irq_oe_n,
  input wire logic other_claim,
  input wire logic [15:0] ext_irq,
  output logic grant_pin_n,
  output logic device_select_pin_n,
  output logic [15:0] irq_pin_in
);
  // ==========
  // A floated request is no request, so grant waits for a driven low
  initial grant_pin_n = 1'b1;
  always @(posedge ref_clk) begin
    grant_pin_n <= request_oe_n | request_out_n;
  end
  assign device_select_pin_n = (devsel_oe_n | devsel_out_n) & ~other_claim;
  assign irq_pin_in = (irq_out & ~irq_oe_n) | (ext_irq & irq_oe_n);
endmodule

/* File: testbench/sideband_monitor.sv */
// Checker for host sideband pin timing
`timescale 1ns/1ps
module sideband_monitor (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic stop_req,
  input wire logic cycle_active,
  input wire logic [3:0] cycle_cmd,
  input wire logic addr_parity_bad_primary,
  input wire logic master_need,
  input wire logic power_state_change,
  input wire logic socket_a_irq,
  input wire logic stop_out_n,
  input wire logic stop_oe_n,
  input wire logic perr_out_n,
  input wire logic perr_oe_n,
  input wire logic syserr_oe_n,
  input wire logic request_out_n,
  input wire logic pm_event_oe_n,
  input wire logic bus_int_a_oe_n,
  input wire logic [15:0] irq_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  // ==========
  // Error pulse is one clock wide
  sequence serr_pulse;
    !syserr_oe_n ##1 syserr_oe_n;
  endsequence
  a_reset_float: assert property (
    !reset_n |=> stop_oe_n && perr_oe_n && syserr_oe_n && (&irq_oe_n))
    else $error("outputs driven in reset");
  a_serr_one_clock: assert property (
    disable iff (!reset_n) $fell(syserr_oe_n) |=> syserr_oe_n)
    else $error("system error held too long");
  a_serr_from_parity: assert property (
    disable iff (!reset_n) $rose(addr_parity_bad_primary) && syserr_oe_n |=> serr_pulse)
    else $error("no system error pulse");
  a_stop_driven: assert property (
    disable iff (!reset_n) stop_req && cycle_active |=> !stop_out_n && !stop_oe_n)
    else $error("stop not driven");
  a_stop_high_first: assert property (
    disable iff (!reset_n) $rose(stop_oe_n) |-> $past(stop_out_n))
    else $error("stop floated from low");
  a_perr_special: assert property (
    disable iff (!reset_n) cycle_cmd == sideband_pkg::CMD_SPECIAL |=> perr_oe_n || perr_out_n)
    else $error("parity error on special cycle");
  a_request_follow: assert property (
    disable iff (!reset_n) master_need |=> !request_out_n)
    else $error("request missing");
  a_pme_follow: assert property (
    disable iff (!reset_n) power_state_change |=> !pm_event_oe_n)
    else $error("power event missing");
  a_int_a_drive: assert property (
    disable iff (!reset_n) ##1 bus_int_a_oe_n == !$past(socket_a_irq))
    else $error("interrupt A wrong");
endmodule
bind host_sideband sideband_monitor mon (.ref_clk, .reset_n, .stop_req, .cycle_active,
  .cycle_cmd, .addr_parity_bad_primary, .master_need, .power_state_change, .socket_a_irq,
  .stop_out_n, .stop_oe_n, .perr_out_n, .perr_oe_n, .syserr_oe_n, .request_out_n,
  .pm_event_oe_n, .bus_int_a_oe_n, .irq_oe_n);

/* File: testbench/testbench.sv */
// Self-checking bench for host sideband routing
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0, reset_n = 1'b0, cfg_load = 1'b0, stop_req = 1'b0, cycle_active = 1'b0;
  logic addr_decode_hit = 1'b0, write_data_phase = 1'b0, data_parity_bad = 1'b0;
  logic addr_parity_bad_primary = 1'b0, addr_parity_bad_secondary = 1'b0, master_need = 1'b0;
  logic power_state_change = 1'b0, socket_a_irq = 1'b0, socket_b_irq = 1'b0, led_state = 1'b0;
  logic serial_irq_frame = 1'b0, socket_a_led = 1'b0, socket_b_led = 1'b0, other_claim = 1'b0;
  logic card_is_16bit = 1'b0, ring_select_b = 1'b0, config_select_pin = 1'b0;
  logic [3:0] cycle_cmd = 4'h0, gpio_out = 4'h0, gpio_dir_out = 4'h0, gpio_in;
  logic [15:0] card_irq_route = 16'h0000, ext_irq = 16'hffff, irq_out, irq_oe_n, irq_pin_in;
  logic [7:0] video_data = 8'h00, video_out, video_oe_n;
  logic [1:0] socket_ring_indicate_n = 2'b11;
  sideband_pkg::mux_cfg_t cfg_in = sideband_pkg::CFG_RESET;
  logic config_selected, any_claimed, grant_held, video_port_enable_in, stop_out_n, stop_oe_n;
  logic devsel_out_n, devsel_oe_n, perr_out_n, perr_oe_n, syserr_oe_n, request_out_n;
  logic request_oe_n, pm_event_oe_n, bus_int_a_oe_n, bus_int_b_oe_n, grant_pin_n;
  logic device_select_pin_n, ring_indicate_out_n, ring_oe_n;
  int fail_count = 0, check_count = 0, cycles = 0;
  always #2.5 ref_clk = ~ref_clk;
  host_sideband uut (.ref_clk, .reset_n, .cfg_in, .cfg_load, .stop_req, .addr_decode_hit,
    .cycle_active, .cycle_cmd, .write_data_phase, .data_parity_bad, .addr_parity_bad_primary,
    .addr_parity_bad_secondary, .master_need, .power_state_change, .socket_a_irq,
    .socket_b_irq, .card_irq_route, .serial_irq_frame, .socket_a_led, .socket_b_led,
    .led_state, .gpio_out, .gpio_dir_out, .card_is_16bit, .ring_select_b, .video_data,
    .config_select_pin, .device_select_pin_n, .grant_pin_n, .irq_pin_in,
    .socket_ring_indicate_n, .config_selected, .any_claimed, .grant_held, .gpio_in,
    .video_port_enable_in, .stop_out_n, .stop_oe_n, .devsel_out_n, .devsel_oe_n, .perr_out_n,
    .perr_oe_n, .syserr_oe_n, .request_out_n, .request_oe_n, .pm_event_oe_n, .bus_int_a_oe_n,
    .bus_int_b_oe_n, .irq_out, .irq_oe_n, .ring_indicate_out_n, .ring_oe_n, .video_out,
    .video_oe_n);
  host_bus_model partner (.ref_clk, .request_out_n, .request_oe_n, .devsel_out_n,
    .devsel_oe_n, .irq_out, .irq_oe_n, .other_claim, .ext_irq, .grant_pin_n,
    .device_select_pin_n, .irq_pin_in);
  // ==========
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    if (fail_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Pin-derived status passes two sync flops, so allow four clocks
  task automatic mode(input logic [2:0] m);
    cfg_in = m;
    cfg_load = 1'b1;
    cyc(1);
    cfg_load = 1'b0;
    cyc(4);
  endtask
  // ==========
  // Scenarios
  task automatic t_bus;
    stop_req = 1'b1;
    cycle_active = 1'b1;
    addr_decode_hit = 1'b1;
    cyc(1);
    stop_req = 1'b0;
    chk("stop", 16'h0000, {stop_out_n, stop_oe_n, devsel_out_n, devsel_oe_n});
    cyc(1);
    chk("stop_high", 16'h0002, {stop_out_n, stop_oe_n});
    cyc(1);
    chk("stop_off", 16'h0001, stop_oe_n);
    addr_decode_hit = 1'b0;
    other_claim = 1'b1;
    config_select_pin = 1'b1;
    for (int k = 0; k < 3; k++) begin
      cycle_cmd = (k == 0) ? sideband_pkg::CMD_CFG_READ :
                  (k == 1) ? sideband_pkg::CMD_CFG_WRITE : 4'h6;
      cyc(4);
      chk("cfg_sel", {15'h0, k < 2}, config_selected);
      chk("claimed", 16'h0001, any_claimed);
    end
  endtask
  task automatic t_errors;
    write_data_phase = 1'b1;
    data_parity_bad = 1'b1;
    addr_parity_bad_primary = 1'b1;
    cyc(1);
    chk("perr", 16'h0000, {perr_out_n, perr_oe_n, syserr_oe_n});
    cycle_cmd = sideband_pkg::CMD_SPECIAL;
    addr_parity_bad_secondary = 1'b1;
    cyc(1);
    chk("serr_end", 16'h0001, syserr_oe_n);
    cyc(1);
    chk("serr_second", 16'h0000, syserr_oe_n);
    cyc(1);
    chk("perr_special", 16'h0001, perr_out_n | perr_oe_n);
    chk("serr_held", 16'h0001, syserr_oe_n);
    addr_parity_bad_primary = 1'b0;
    addr_parity_bad_secondary = 1'b0;
    data_parity_bad = 1'b0;
    cycle_active = 1'b0;
  endtask
  task automatic t_requests;
    master_need = 1'b1;
    power_state_change = 1'b1;
    socket_a_irq = 1'b1;
    socket_b_irq = 1'b1;
    cyc(6);
    chk("req", 16'h0003, {~request_out_n, grant_held});
    chk("pme_int", 16'h0001, {pm_event_oe_n, bus_int_a_oe_n, ~bus_int_b_oe_n});
    master_need = 1'b0;
    power_state_change = 1'b0;
    socket_a_irq = 1'b0;
    cyc(6);
    chk("grant_off", 16'h0001, {grant_held, bus_int_a_oe_n});
  endtask
  task automatic t_modes;
    card_irq_route = 16'h5aa5;
    cyc(1);
    chk("legacy", 16'h5aa5 & sideband_pkg::IRQ_PRESENT, irq_out);
    chk("legacy_oe", ~sideband_pkg::IRQ_PRESENT, irq_oe_n);
    mode(3'b100);
    chk("led", 16'h0000, irq_out[12]);
    serial_irq_frame = 1'b1;
    socket_b_led = 1'b1;
    gpio_dir_out = 4'h3;
    gpio_out = 4'h1;
    ext_irq = 16'h0020;
    mode(3'b010);
    chk("serial", 16'h0002, {irq_out[9], irq_out[10], irq_out[11]});
    chk("gpio_out", 16'h0004, {irq_out[4:3], irq_oe_n[4:3]});
    chk("gpio_in", 16'h0001, gpio_in[3:2]);
    chk("video_off", 16'h01ff, {irq_oe_n[15], video_oe_n});
    ext_irq = 16'h8000;
    video_data = 8'h5a;
    cyc(4);
    chk("video_en", 16'h0001, video_port_enable_in);
    chk("video_on", 16'h005a, {video_oe_n, video_out});
    card_is_16bit = 1'b1;
    socket_ring_indicate_n = 2'b10;
    mode(3'b001);
    chk("ring", 16'h0000, {ring_oe_n, ring_indicate_out_n});
    ring_select_b = 1'b1;
    cyc(4);
    chk("ring_b", 16'h0001, ring_indicate_out_n);
  endtask
  // Mid-run reset must float everything and drop the mux back to interrupt duty
  task automatic t_reset;
    reset_n = 1'b0;
    cyc(2);
    chk("rst_float", 16'h0001, ring_oe_n & (&irq_oe_n) & (&video_oe_n));
    reset_n = 1'b1;
    cyc(3);
    chk("rst_cfg", ~sideband_pkg::IRQ_PRESENT, irq_oe_n);
    chk("rst_ring", 16'h0001, ring_oe_n);
  endtask
  // ==========
  // Run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    cyc(7);
    chk("reset_float", 16'h0001,
        stop_oe_n & perr_oe_n & request_oe_n & ring_oe_n & (&irq_oe_n));
    cyc(1);
    reset_n = 1'b1;
    cyc(3);
    t_bus();
    t_errors();
    t_requests();
    t_modes();
    t_reset();
    final_report();
  end
endmodule
